// [logic/pao_pkg.sv]
// Package for the pipelined converter output port: widths, latency, reset values.
// Assumes nothing beyond a SystemVerilog compiler.
package pao_pkg;
  localparam int unsigned PAO_DATA_W = 14;
  localparam int unsigned PAO_STAGES = 4;
  localparam int unsigned PAO_LATENCY = 5;
  localparam int unsigned PAO_FIFO_DEPTH = 32;
  localparam int unsigned PAO_FIFO_AW = 5;
  localparam int unsigned PAO_MSB_POS = 13;
  localparam int unsigned PAO_STAGE_BITS = 4;
  localparam logic [13:0] PAO_WORD_RST = 14'h0000;
  localparam logic [13:0] PAO_CODE_MAX = 14'h3fff;
  localparam logic [13:0] PAO_CODE_MIN = 14'h0000;
  localparam logic [15:0] PAO_SAMPLE_RST = 16'h0000;
endpackage

// [logic/pao_fifo.sv]
// Word FIFO with valid/ready on both sides, flip-flop storage indexed by pointer.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ns
module pao_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Async reset, high
  input wire logic [WIDTH-1:0] in_data_i, // Write word
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Not full
  output logic [WIDTH-1:0] out_data_o, // Head word
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i // Drain
);
  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } pao_fifo_st_type;
  pao_fifo_st_type s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Pointer compare gives honest full and empty
  assign empty = (s_q.wr == s_q.rd);
  assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
  assign push = in_valid_i && !full;
  assign pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[s_q.rd[AW-1:0]];

  // Next pointers
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  // Register pointers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[s_q.wr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// [logic/pao_top.sv]
// Digital side of a 14-bit pipelined converter: encode-clock pipeline, correction,
// format select, overflow flag, output FIFO and tri-state sample bus with strobe.
// Assumes sample codes arrive as 16-bit two's complement on encode_clock, and that
// the capture logic latches words on the rising edge of the data-valid strobe.
`timescale 1ns/1ns

// Overview of operation
// - Format select low inverts MSB for two's complement; high gives offset binary.
// - A sample is taken on the rising edge of the true encode clock.
// - Data drives while output enable low is low; high-impedance while it is high.
// - Overflow flag goes high when a sample exceeded range either way.
// - Result is a 14-bit bus, LSB bit 0 up to MSB bit 13.
// - Result appears five encode cycles after sampling, one per cycle.
// - Four pipelined stages; only the first-stage input register runs on the falling encode edge, all later stages on the rising.
// - Track while encode low, hold at rising edge, pass on during high.
// - Stage partial results are delayed, aligned and combined by correction logic.
module pao_top
  import pao_pkg::*;
(
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic sys_rst_i, // Async reset, high
  input wire logic encode_clock, // Link encode clock
  input wire logic [15:0] analog_code_i, // Tracked input as signed code
  input wire logic format_select_i, // Low: two's complement
  input wire logic out_enable_n_i, // Active-low output enable pin
  output logic [pao_pkg::PAO_DATA_W-1:0] sample_word_o, // Data bus out
  output logic [pao_pkg::PAO_DATA_W-1:0] sample_word_oe_o, // Per-bit drive enable
  output logic range_overflow_flag_o, // Over/under range of word
  output logic data_valid_strobe_o, // Latch on rising edge
  output logic fifo_ready_o // FIFO can take a word
);
  localparam int unsigned FW = PAO_DATA_W + 1;

  // Encode-domain state
  typedef struct packed {
    logic [15:0] held;
    logic [PAO_STAGES-1:0][PAO_STAGE_BITS-1:0] part;
    logic [PAO_STAGES-1:0][PAO_STAGE_BITS*PAO_STAGES-1:0] align;
    logic [PAO_STAGES-1:0] ovr;
    logic [PAO_DATA_W-1:0] word;
    logic word_ovr;
    logic tog;
    logic [FW-1:0] xfer;
  } pao_enc_st_type;

  // First-stage input state on the low phase; the hold register rises with the encode domain
  typedef struct packed {
    logic [15:0] s1_in;
  } pao_neg_st_type;

  // System-domain state
  typedef struct packed {
    logic [2:0] tog_sync;
    logic [FW-1:0] cap;
    logic cap_valid;
    logic fmt_m;
    logic fmt;
    logic oe_m;
    logic oe_n;
    logic [PAO_DATA_W-1:0] bus;
    logic [PAO_DATA_W-1:0] bus_oe;
    logic ovf;
    logic strobe;
    logic [1:0] phase;
    logic rdy;
  } pao_sys_st_type;

  pao_enc_st_type e_q, e_d;
  pao_neg_st_type n_q, n_d;
  pao_sys_st_type s_q, s_d;
  logic [FW-1:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  logic [15:0] res;
  logic [PAO_DATA_W-1:0] clamped;
  logic over_range;

  // Clamp the signed input to 14 bits and detect over/under range
  always_comb begin
    over_range = 1'b0;
    clamped = n_q.s1_in[PAO_DATA_W-1:0];
    if ($signed(n_q.s1_in) > $signed(16'sh1fff)) begin
      over_range = 1'b1;
      clamped = 14'h1fff;
    end else if ($signed(n_q.s1_in) < $signed(16'she000)) begin
      over_range = 1'b1;
      clamped = 14'h2000;
    end
    res = {2'b00, clamped ^ 14'h2000}; // Offset binary code for quantising
  end

  // Encode pipeline: only the first stage takes the opposite phase, via the low-phase register
  always_comb begin
    e_d = e_q;
    e_d.held = analog_code_i;
    // Stage quantisers take successive nibbles of the residue
    // Alignment delay line so all partials belong to one sample
    e_d.align[0] = {res[13:10], res[9:6], res[5:2], {2'b00, res[1:0]}};
    // Last stage gets the two leftover bits, padded so no slice runs below bit 0
    for (int i = 0; i < PAO_STAGES; i++) begin
      e_d.part[i] = e_d.align[0][PAO_STAGE_BITS*(PAO_STAGES-i)-1 -: PAO_STAGE_BITS];
    end
    for (int i = 1; i < PAO_STAGES; i++) begin
      e_d.align[i] = e_q.align[i-1];
    end
    e_d.ovr = {e_q.ovr[PAO_STAGES-2:0], over_range};
    // Correction logic recombines aligned partials into one word
    e_d.word = {e_q.align[PAO_STAGES-2][15:12], e_q.align[PAO_STAGES-2][11:8],
                e_q.align[PAO_STAGES-2][7:4], e_q.align[PAO_STAGES-2][1:0]};
    e_d.word_ovr = e_q.ovr[PAO_STAGES-2];
    // Publish the aligned word across domains
    e_d.xfer = {e_q.word_ovr, e_q.word};
    e_d.tog = ~e_q.tog;
  end

  // Low phase passes the held sample on to the first stage
  always_comb begin
    n_d.s1_in = e_q.held;
  end

  always_ff @(posedge encode_clock or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      e_q <= '0;
    end else begin
      e_q <= e_d;
    end
  end

  always_ff @(negedge encode_clock or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      n_q <= '0;
    end else begin
      n_q <= n_d;
    end
  end

  // System domain: toggle sync, capture, format, output and strobe
  always_comb begin
    s_d = s_q;
    s_d.tog_sync = {s_q.tog_sync[1:0], e_q.tog};
    s_d.cap_valid = s_q.tog_sync[2] ^ s_q.tog_sync[1];
    if (s_q.tog_sync[2] ^ s_q.tog_sync[1]) begin
      s_d.cap = e_q.xfer; // Stable: changed on the same encode edge as the toggle
    end
    s_d.fmt_m = format_select_i;
    s_d.fmt = s_q.fmt_m;
    s_d.oe_m = out_enable_n_i;
    s_d.oe_n = s_q.oe_m;
    s_d.rdy = fifo_in_ready;
    s_d.bus_oe = s_q.oe_n ? '0 : '1;
    // Strobe low with new data, rising two cycles later
    unique case (s_q.phase)
      2'd0: begin
        if (fifo_out_valid) begin
          s_d.bus = fifo_out[PAO_DATA_W-1:0];
          s_d.bus[PAO_MSB_POS] = fifo_out[PAO_MSB_POS] ^ ~s_q.fmt;
          s_d.ovf = fifo_out[PAO_DATA_W];
          s_d.strobe = 1'b0;
          s_d.phase = 2'd1;
        end
      end
      2'd1: begin
        s_d.phase = 2'd2;
      end
      default: begin
        s_d.strobe = 1'b1;
        s_d.phase = 2'd0;
      end
    endcase
  end

  assign fifo_pop = (s_q.phase == 2'd0) && fifo_out_valid;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.strobe <= 1'b1; // Idle high so the first word also starts with a fall
      s_q.oe_m <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.fmt_m <= 1'b1;
      s_q.fmt <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Output FIFO between capture and the bus
  pao_fifo #(
    .WIDTH(FW),
    .DEPTH(PAO_FIFO_DEPTH),
    .AW(PAO_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(s_q.cap),
    .in_valid_i(s_q.cap_valid),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop)
  );

  assign sample_word_o = s_q.bus;
  assign sample_word_oe_o = s_q.bus_oe;
  assign range_overflow_flag_o = s_q.ovf;
  assign data_valid_strobe_o = s_q.strobe;
  assign fifo_ready_o = s_q.rdy;
endmodule

// [testbench/pao_top_asserts.sv]
// Port checker for pao_top, bound below.
// Assumes clk_i alone clocks the ports watched here.
`timescale 1ns/1ns
module pao_top_asserts (
  input wire logic clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic out_enable_n_i, // Enable pin
  input wire logic [13:0] sample_word_o, // Word
  input wire logic [13:0] sample_word_oe_o, // Enables
  input wire logic range_overflow_flag_o, // Flag
  input wire logic data_valid_strobe_o // Strobe
);
  wire s = data_valid_strobe_o;
  wire [13:0] w = sample_word_o;
  wire [13:0] oe = sample_word_oe_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Strobe low one more clock, then high
  sequence s_walk;
    !s ##1 s;
  endsequence
  chk_strobe_walk: assert property ($fell(s) |=> s_walk)
    else $error("strobe walk");
  chk_word_rate: assert property ($fell(s) |-> ##[3:8] $fell(s))
    else $error("word rate");
  chk_word_hold: assert property (!$fell(s) |-> $stable(w))
    else $error("word moved");
  chk_flag_hold: assert property (!$fell(s) |-> $stable(range_overflow_flag_o))
    else $error("flag moved");
  chk_flag_code: assert property (range_overflow_flag_o |-> w[12:0] inside {13'h0, 13'h1fff})
    else $error("flag on inner code");
  chk_oe_off: assert property (out_enable_n_i [*5] |-> oe == 14'h0)
    else $error("driven while off");
  chk_oe_on: assert property (!out_enable_n_i [*5] |-> oe == 14'h3fff)
    else $error("idle while on");
  chk_oe_whole: assert property (oe == 14'h0 || oe == 14'h3fff)
    else $error("enables split");
endmodule
bind pao_top pao_top_asserts u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
  .out_enable_n_i(out_enable_n_i), .sample_word_o(sample_word_o),
  .sample_word_oe_o(sample_word_oe_o), .range_overflow_flag_o(range_overflow_flag_o),
  .data_valid_strobe_o(data_valid_strobe_o));

// [testbench/pao_capture.sv]
// Capture logic model on the far side of the sample bus.
// Assumes the bench resolves the bus from the drive enables.
`timescale 1ns/1ns
module pao_capture (
  input wire logic strobe_i, // Data valid strobe
  input wire logic [13:0] bus_i, // Resolved bus
  input wire logic flag_i // Overflow flag
);
  logic [14:0] q[$];
  // Latch flag and word on each strobe rise
  always @(posedge strobe_i) q.push_back({flag_i, bus_i});
endmodule

// [testbench/tb.sv]
// Bench for pao_top: random codes per encode cycle, words checked in order.
// Assumes pao_capture as far side and the bound checker.
`timescale 1ns/1ns
module tb;
  import pao_pkg::*;
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
$display("FAIL %s exp %h got %h", n, e, g); end end
  logic clk_i = 0, sys_rst_i = 1, encode_clock = 0, format_select_i = 1;
  logic out_enable_n_i = 0, live = 0, stb, ovf, rdy;
  logic [15:0] analog_code_i = 16'h0000;
  logic [13:0] word, oe;
  logic [14:0] g, e, exp_q[$];
  wire [13:0] bus;
  int fail_count = 0, cmp_count = 0, enc_cnt = 0, enc_last = 0, enc0 = 0;
  int seed = 32'h48a89922, r, n, skip;
  // Clocks, encode offset in phase
  always #5 clk_i = ~clk_i;
  initial begin
    #2;
    forever #16 encode_clock = ~encode_clock;
  end
  pao_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .encode_clock(encode_clock),
    .analog_code_i(analog_code_i), .format_select_i(format_select_i),
    .out_enable_n_i(out_enable_n_i), .sample_word_o(word), .sample_word_oe_o(oe),
    .range_overflow_flag_o(ovf), .data_valid_strobe_o(stb), .fifo_ready_o(rdy));
  pao_capture u_cap (.strobe_i(stb), .bus_i(bus), .flag_i(ovf));
  // Bus level from the drive enables
  for (genvar i = 0; i < 14; i++) begin : g_bus
    assign bus[i] = oe[i] ? word[i] : 1'bz;
  end
  // Expected word: clamp, offset, MSB inverted when format low
  function automatic logic [14:0] expf(logic [15:0] c, logic f);
    int v;
    logic o;
    v = $signed(c);
    o = v > 8191 || v < -8192;
    v = o ? (v > 0 ? 16383 : 0) : v + 8192;
    return {o, 14'(v) ^ {~f, 13'h0}};
  endfunction
  // Record the code held at each encode rise
  always @(posedge encode_clock) begin
    enc_cnt++;
    if (live && exp_q.size() == 0) enc0 = enc_cnt;
    if (live) exp_q.push_back(expf(analog_code_i, format_select_i));
  end
  // One new random code per encode cycle
  always @(posedge clk_i) begin
    r = $random(seed);
    if (enc_cnt != enc_last && live) analog_code_i <= r[0] ? r[15:0] : {{3{r[15]}}, r[15:3]};
    enc_last <= enc_cnt;
  end
  task automatic run_phase(input logic f);
    sys_rst_i <= 1;
    format_select_i <= f;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 0;
    u_cap.q.delete();
    analog_code_i <= 16'h0000;
    n = 0;
    skip = 0;
    repeat (40) @(posedge clk_i);
    live <= 1;
    analog_code_i <= 16'h0123;
    for (int t = 0; t < 900 && (t < 201 || exp_q.size() > 0); t++) begin
      @(posedge clk_i);
      if (t == 200) live <= 0;
      while (u_cap.q.size() > 0 && exp_q.size() > 0) begin
        g = u_cap.q.pop_front();
        if (n == 0 && g !== exp_q[0] && skip < 40) skip++;
        else begin
          if (n == 0) `CHK("latency", 1'b1, enc_cnt - enc0 inside {[5:7]})
          e = exp_q.pop_front();
          `CHK("word", e, g)
          n++;
        end
      end
    end
    `CHK("count", 1'b1, n > 55 && exp_q.size() == 0)
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    run_phase(1'b1);
    run_phase(1'b0);
    `CHK("ready", 1'b1, rdy)
    `CHK("oe on", 14'h3fff, oe)
    out_enable_n_i <= 1;
    repeat (6) @(posedge clk_i);
    `CHK("oe off", 14'h0, oe)
    `CHK("bus", {14{1'bz}}, bus)
    test_done();
  end
endmodule
